// *** core/rsc_pkg.sv ***
package rsc_pkg;

  // ==========================================================
  // Command set
  typedef enum logic [3:0] {
    CMD_NONE              = 4'h0,
    CMD_CLEAR_STATUS      = 4'h1,
    CMD_COMM_RESET        = 4'h2,
    CMD_OP_DONE           = 4'h3,
    CMD_OP_DONE_QUERY     = 4'h4,
    CMD_WAIT              = 4'h5,
    CMD_UNIT_SELECT       = 4'h6,
    CMD_CONTROL_SRC       = 4'h7,
    CMD_CONTROL_QUERY     = 4'h8,
    CMD_EVENT_MASK        = 4'h9,
    CMD_EVENT_MASK_QUERY  = 4'hA,
    CMD_EVENT_QUERY       = 4'hB,
    CMD_SERVICE_MASK      = 4'hC,
    CMD_SERVICE_MASK_QUERY = 4'hD,
    CMD_SUMMARY_QUERY     = 4'hE
  } rsc_cmd_e;

  typedef struct packed {
    rsc_cmd_e op;
    logic [7:0] arg;
  } rsc_cmd_s;

  // ==========================================================
  // Control source states, Gray coded along local-remote-lockout
  typedef enum logic [1:0] {
    CTRL_LOCAL   = 2'b00,
    CTRL_REMOTE  = 2'b01,
    CTRL_LOCKOUT = 2'b11
  } rsc_ctrl_e;

  localparam logic [1:0] CODE_LOCAL = 2'h0;
  localparam logic [1:0] CODE_REMOTE = 2'h1;
  localparam logic [1:0] CODE_LOCKOUT = 2'h2;

  // ==========================================================
  // Register layout and reset values
  localparam logic [7:0] EVENT_RESET = 8'h80;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [1:0] LINK_RESET = 2'h0;
  localparam int BIT_TIMEOUT = 0;
  localparam int BIT_FAULT = 1;
  localparam int BIT_MAV = 4;
  localparam int BIT_ESB = 5;
  localparam int BIT_MSS = 6;
  localparam int EVT_BIT_DONE = 0;
  localparam logic [7:0] SUMMARY_USED = 8'h33;
  localparam logic [7:0] REPLY_DONE = 8'h01;

  // ==========================================================
  // Local bus unit numbers
  localparam logic [4:0] UNIT_DEFAULT = 5'h01;
  localparam logic [7:0] UNIT_MIN = 8'h01;
  localparam logic [7:0] UNIT_MAX = 8'h1E;

  function automatic logic unit_in_range(input logic [7:0] arg);
    unit_in_range = (arg >= UNIT_MIN) && (arg <= UNIT_MAX);
  endfunction

  function automatic logic [1:0] ctrl_code(input rsc_ctrl_e st);
    case (st)
      CTRL_REMOTE: ctrl_code = CODE_REMOTE;
      CTRL_LOCKOUT: ctrl_code = CODE_LOCKOUT;
      default: ctrl_code = CODE_LOCAL;
    endcase
  endfunction

endpackage

// *** core/rsc_reply.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsc_reply (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Loading side
  input wire logic flush,
  input wire logic load,
  input wire logic [7:0] loadData,
  // Host side
  input wire logic replyReady,
  output logic replyValid,
  output logic [7:0] replyData
);

  // ==========================================================
  // One-slot output queue; the command side stalls while it is full
  logic valid_reg;
  logic [7:0] data_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      valid_reg <= 1'b0;
    end else if (flush) begin
      valid_reg <= 1'b0;
    end else if (load) begin
      valid_reg <= 1'b1;
    end else if (replyReady) begin
      valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_reg <= 8'h00;
    end else if (load) begin
      data_reg <= loadData;
    end
  end

  assign replyValid = valid_reg;
  assign replyData = data_reg;

endmodule
`default_nettype wire

// *** core/rsc_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsc_status (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Clears
  input wire logic clearStatus,
  input wire logic clearMasks,
  // Events
  input wire logic [7:0] eventSet,
  input wire logic eventRead,
  input wire logic linkFault,
  input wire logic linkTimeout,
  input wire logic messageReady,
  input wire logic serialPoll,
  // Mask writes
  input wire logic eventMaskWr,
  input wire logic serviceMaskWr,
  input wire logic [7:0] maskData,
  // State
  output logic [7:0] eventReg,
  output logic [7:0] eventMask,
  output logic [7:0] serviceMask,
  output logic [7:0] summaryByte,
  output logic serviceRequest
);

  logic [7:0] evt_reg;
  logic [7:0] ese_reg;
  logic [7:0] sre_reg;
  logic [1:0] link_reg;
  logic mssPrev_reg;
  logic rqs_reg;
  logic esb;
  logic mss;

  // ==========================================================
  // Sticky event and link bits; a new event beats a clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      evt_reg <= rsc_pkg::EVENT_RESET;
    end else begin
      evt_reg <= ((clearStatus || eventRead) ? 8'h00 : evt_reg) | eventSet;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      link_reg <= rsc_pkg::LINK_RESET;
    end else begin
      link_reg <= (clearStatus ? 2'h0 : link_reg) | {linkFault, linkTimeout};
    end
  end

  // ==========================================================
  // Enable registers
  always_ff @(posedge core_clk) begin
    if (reset || clearMasks) begin
      ese_reg <= rsc_pkg::MASK_RESET;
    end else if (eventMaskWr) begin
      ese_reg <= maskData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || clearMasks) begin
      sre_reg <= rsc_pkg::MASK_RESET;
    end else if (serviceMaskWr) begin
      sre_reg <= maskData;
    end
  end

  // ==========================================================
  // Summary byte in the 488.2 model; unused positions never count
  always_comb begin
    esb = |(evt_reg & ese_reg);
    summaryByte = 8'h00;
    summaryByte[rsc_pkg::BIT_TIMEOUT] = link_reg[0];
    summaryByte[rsc_pkg::BIT_FAULT] = link_reg[1];
    summaryByte[rsc_pkg::BIT_MAV] = messageReady;
    summaryByte[rsc_pkg::BIT_ESB] = esb;
    mss = |(summaryByte & sre_reg & rsc_pkg::SUMMARY_USED);
    summaryByte[rsc_pkg::BIT_MSS] = mss;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mssPrev_reg <= 1'b0;
      rqs_reg <= 1'b0;
    end else begin
      mssPrev_reg <= mss;
      rqs_reg <= (mss && !mssPrev_reg) || (rqs_reg && mss && !serialPoll);
    end
  end

  assign eventReg = evt_reg;
  assign eventMask = ese_reg;
  assign serviceMask = sre_reg;
  assign serviceRequest = rqs_reg;

endmodule
`default_nettype wire

// *** core/rsc_command_unit.sv ***
// Summary of operation
// - Communication reset flushes all buffers and clears status byte and event register.
// - Communication reset also zeroes both enable registers and drops talker/listener.
// - Operation-complete command sets event register bit 0.
// - Service request after that depends on event and service enable masks.
// - Operation-complete query answers 1 once executed.
// - Wait command does nothing; only overlapped commands exist; no query.
// - Unit select takes numbers 1 to 30 for local bus routing.
// - A unit number absent on the local bus raises no error.
// - Selected unit number is 1, the master, after reset.
// - Control source: 0 local, 1 remote, 2 remote with lockout.
// - Control query while local switches to remote first, answering 1.
// - Summary bits: 6 request/summary, 5 event, 4 message, 1 fault, 0 timeout.
// - A zero enable bit masks its summary bit; all zero by default.
// - A one enable bit lets its summary bit request service.
// - Summary byte and masking follow the 488.2 status model.
// - Master summary is OR of enabled bits; request bit sets on its rise.
// - Message bit shows an answer waiting in the output queue.
`timescale 1ns/1ps
`default_nettype none
module rsc_command_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Parsed command stream
  input wire logic cmdValid,
  input wire rsc_pkg::rsc_cmd_s cmdWord,
  output logic cmdReady,
  // Answer stream
  output logic replyValid,
  output logic [7:0] replyData,
  input wire logic replyReady,
  // Event sources
  input wire logic [7:0] deviceEvents,
  input wire logic localLinkFault,
  input wire logic localLinkTimeout,
  input wire logic serialPoll,
  input wire logic panelLocalKey,
  // Control outputs
  output logic flushBuffers,
  output logic dropAddressing,
  output logic [4:0] unitSelect,
  output logic [1:0] controlCode,
  output logic remoteActive,
  output logic lockoutActive,
  // Status outputs
  output logic [7:0] statusByte,
  output logic serviceRequest
);

  logic take;
  logic isClear;
  logic isReset;
  logic [7:0] eventSet;
  logic replyLoad;
  logic [7:0] replyValue;
  logic [7:0] eventReg;
  logic [7:0] eventMask;
  logic [7:0] serviceMask;
  logic flush_reg;
  logic drop_reg;
  logic [4:0] unit_reg;
  rsc_pkg::rsc_ctrl_e ctrl_reg;

  // ==========================================================
  // Command acceptance
  // Commands stall while an answer is unread, so a query never overwrites one
  assign cmdReady = !replyValid;
  assign take = cmdValid && cmdReady;
  assign isClear = take && (cmdWord.op == rsc_pkg::CMD_CLEAR_STATUS);
  assign isReset = take && (cmdWord.op == rsc_pkg::CMD_COMM_RESET);

  // ==========================================================
  // Event sources into the event register
  always_comb begin
    eventSet = deviceEvents;
    if (take && (cmdWord.op == rsc_pkg::CMD_OP_DONE)) begin
      eventSet[rsc_pkg::EVT_BIT_DONE] = 1'b1;
    end
  end

  // ==========================================================
  // Flush and addressing pulses, one cycle after the command
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= isClear || isReset;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      drop_reg <= 1'b0;
    end else begin
      drop_reg <= isReset;
    end
  end

  // ==========================================================
  // Local bus unit; out-of-range numbers are dropped silently
  always_ff @(posedge core_clk) begin
    if (reset) begin
      unit_reg <= rsc_pkg::UNIT_DEFAULT;
    end else if (take && (cmdWord.op == rsc_pkg::CMD_UNIT_SELECT)
                 && rsc_pkg::unit_in_range(cmdWord.arg)) begin
      unit_reg <= cmdWord.arg[4:0];
    end
  end

  // ==========================================================
  // Control source state; lockout ignores the panel key
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_reg <= rsc_pkg::CTRL_LOCAL;
    end else if (take && (cmdWord.op == rsc_pkg::CMD_CONTROL_SRC)) begin
      case (cmdWord.arg)
        8'h00: ctrl_reg <= rsc_pkg::CTRL_LOCAL;
        8'h01: ctrl_reg <= rsc_pkg::CTRL_REMOTE;
        8'h02: ctrl_reg <= rsc_pkg::CTRL_LOCKOUT;
        default: ctrl_reg <= ctrl_reg;
      endcase
    end else if (take && (cmdWord.op == rsc_pkg::CMD_CONTROL_QUERY)) begin
      if (ctrl_reg == rsc_pkg::CTRL_LOCAL) begin
        ctrl_reg <= rsc_pkg::CTRL_REMOTE;
      end
    end else if (panelLocalKey && (ctrl_reg == rsc_pkg::CTRL_REMOTE)) begin
      ctrl_reg <= rsc_pkg::CTRL_LOCAL;
    end
  end

  // ==========================================================
  // Answer selection
  always_comb begin
    replyLoad = 1'b0;
    replyValue = 8'h00;
    if (take) begin
      case (cmdWord.op)
        rsc_pkg::CMD_OP_DONE_QUERY: begin
          replyLoad = 1'b1;
          replyValue = rsc_pkg::REPLY_DONE;
        end
        rsc_pkg::CMD_CONTROL_QUERY: begin
          replyLoad = 1'b1;
          if (ctrl_reg == rsc_pkg::CTRL_LOCAL) begin
            replyValue = {6'h00, rsc_pkg::CODE_REMOTE};
          end else begin
            replyValue = {6'h00, rsc_pkg::ctrl_code(ctrl_reg)};
          end
        end
        rsc_pkg::CMD_EVENT_MASK_QUERY: begin
          replyLoad = 1'b1;
          replyValue = eventMask;
        end
        rsc_pkg::CMD_EVENT_QUERY: begin
          replyLoad = 1'b1;
          replyValue = eventReg;
        end
        rsc_pkg::CMD_SERVICE_MASK_QUERY: begin
          replyLoad = 1'b1;
          replyValue = serviceMask;
        end
        rsc_pkg::CMD_SUMMARY_QUERY: begin
          replyLoad = 1'b1;
          replyValue = statusByte;
        end
        default: begin
          // Wait command lands here: nothing to do, all work is overlapped
          replyLoad = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Submodules
  rsc_reply u_reply (
    .core_clk(core_clk),
    .reset(reset),
    .flush(isClear || isReset),
    .load(replyLoad),
    .loadData(replyValue),
    .replyReady(replyReady),
    .replyValid(replyValid),
    .replyData(replyData)
  );

  rsc_status u_status (
    .core_clk(core_clk),
    .reset(reset),
    .clearStatus(isClear || isReset),
    .clearMasks(isReset),
    .eventSet(eventSet),
    .eventRead(take && (cmdWord.op == rsc_pkg::CMD_EVENT_QUERY)),
    .linkFault(localLinkFault),
    .linkTimeout(localLinkTimeout),
    .messageReady(replyValid),
    .serialPoll(serialPoll),
    .eventMaskWr(take && (cmdWord.op == rsc_pkg::CMD_EVENT_MASK)),
    .serviceMaskWr(take && (cmdWord.op == rsc_pkg::CMD_SERVICE_MASK)),
    .maskData(cmdWord.arg),
    .eventReg(eventReg),
    .eventMask(eventMask),
    .serviceMask(serviceMask),
    .summaryByte(statusByte),
    .serviceRequest(serviceRequest)
  );

  assign flushBuffers = flush_reg;
  assign dropAddressing = drop_reg;
  assign unitSelect = unit_reg;
  assign controlCode = rsc_pkg::ctrl_code(ctrl_reg);
  assign remoteActive = (ctrl_reg != rsc_pkg::CTRL_LOCAL);
  assign lockoutActive = (ctrl_reg == rsc_pkg::CTRL_LOCKOUT);

  // ==========================================================
  // Checks
  chk_reset_clears_masks: assert property (@(posedge core_clk) disable iff (reset)
    isReset |=> (eventMask == 8'h00) && (serviceMask == 8'h00) && dropAddressing)
    else $error("comm reset left an enable mask set");

  chk_reset_clears_status: assert property (@(posedge core_clk) disable iff (reset)
    (isReset || isClear) && (deviceEvents == 8'h00) && !localLinkFault
      && !localLinkTimeout |=> (eventReg == 8'h00) && (statusByte == 8'h00) && flushBuffers)
    else $error("clear left status bits set");

  chk_clear_before_next: assert property (@(posedge core_clk) disable iff (reset)
    isReset |=> !replyValid && cmdReady)
    else $error("next command would see stale state");

  chk_done_sets_event: assert property (@(posedge core_clk) disable iff (reset)
    take && (cmdWord.op == rsc_pkg::CMD_OP_DONE) |=> eventReg[rsc_pkg::EVT_BIT_DONE])
    else $error("operation complete bit not set");

  chk_done_query_one: assert property (@(posedge core_clk) disable iff (reset)
    take && (cmdWord.op == rsc_pkg::CMD_OP_DONE_QUERY) |=> replyValid && (replyData == 8'h01))
    else $error("operation complete query did not answer 1");

  chk_wait_no_effect: assert property (@(posedge core_clk) disable iff (reset)
    take && (cmdWord.op == rsc_pkg::CMD_WAIT) |=> !replyValid && $stable(unitSelect)
      && $stable(controlCode))
    else $error("wait command had an effect");

  chk_unit_in_range: assert property (@(posedge core_clk) disable iff (reset)
    (unitSelect >= 5'h01) && (unitSelect <= 5'h1E))
    else $error("unit number out of range");

  chk_unit_select: assert property (@(posedge core_clk) disable iff (reset)
    take && (cmdWord.op == rsc_pkg::CMD_UNIT_SELECT) |=>
      (unitSelect == (rsc_pkg::unit_in_range($past(cmdWord.arg)) ?
       $past(cmdWord.arg[4:0]) : $past(unitSelect))))
    else $error("unit select not applied");

  chk_unit_default: assert property (@(posedge core_clk) disable iff (reset)
    $past(reset) |-> (unitSelect == 5'h01))
    else $error("unit number not 1 after reset");

  chk_query_goes_remote: assert property (@(posedge core_clk) disable iff (reset)
    take && (cmdWord.op == rsc_pkg::CMD_CONTROL_QUERY) && !remoteActive |=>
      remoteActive && !lockoutActive && (replyData == 8'h01))
    else $error("control query while local did not go remote");

  chk_summary_bit: assert property (@(posedge core_clk) disable iff (reset)
    statusByte[6] == |(statusByte[5:0] & serviceMask[5:0]))
    else $error("master summary mismatch");

  chk_request_rise: assert property (@(posedge core_clk) disable iff (reset)
    $rose(statusByte[6]) |=> serviceRequest)
    else $error("service request missed summary rise");

  chk_mask_blocks: assert property (@(posedge core_clk) disable iff (reset)
    (serviceMask == 8'h00) |-> !statusByte[6] ##1 (!serviceRequest || $past(serviceMask) != 8'h00))
    else $error("masked bits raised a request");

  chk_message_bit: assert property (@(posedge core_clk) disable iff (reset)
    statusByte[4] == replyValid)
    else $error("message bit disagrees with queue");

  chk_clear_keeps_masks: assert property (@(posedge core_clk) disable iff (reset)
    isClear |=> $stable(eventMask) && $stable(serviceMask) && !dropAddressing)
    else $error("status clear touched an enable mask");

  chk_control_code: assert property (@(posedge core_clk) disable iff (reset)
    take && (cmdWord.op == rsc_pkg::CMD_CONTROL_SRC) && (cmdWord.arg <= 8'h02) |=>
      (controlCode == $past(cmdWord.arg[1:0])))
    else $error("control source code not applied");

  chk_lockout_holds: assert property (@(posedge core_clk) disable iff (reset)
    lockoutActive && !(take && (cmdWord.op == rsc_pkg::CMD_CONTROL_SRC)) |=> lockoutActive)
    else $error("lockout left without a control command");

  chk_panel_to_local: assert property (@(posedge core_clk) disable iff (reset)
    panelLocalKey && (controlCode == 2'h1) && !take |=> (controlCode == 2'h0))
    else $error("panel key did not return to local");

  chk_unused_zero: assert property (@(posedge core_clk) disable iff (reset)
    (statusByte[7] == 1'b0) && (statusByte[3:2] == 2'h0))
    else $error("unused summary bit set");

  chk_request_drops: assert property (@(posedge core_clk) disable iff (reset)
    !statusByte[6] |=> !serviceRequest)
    else $error("request bit held without summary");

  chk_mask_passes: assert property (@(posedge core_clk) disable iff (reset)
    |(statusByte[5:0] & serviceMask[5:0] & 6'h33) |-> statusByte[6])
    else $error("enabled bit did not reach the summary");

  chk_done_sticky: assert property (@(posedge core_clk) disable iff (reset)
    eventReg[rsc_pkg::EVT_BIT_DONE] && !isClear && !isReset
      && !(take && (cmdWord.op == rsc_pkg::CMD_EVENT_QUERY))
      |=> eventReg[rsc_pkg::EVT_BIT_DONE])
    else $error("operation complete bit lost");

  chk_event_read_clears: assert property (@(posedge core_clk) disable iff (reset)
    take && (cmdWord.op == rsc_pkg::CMD_EVENT_QUERY) && (deviceEvents == 8'h00) |=>
      (eventReg == 8'h00) && (replyData == $past(eventReg)))
    else $error("event query did not return and clear");

  cov_reset_cmd: cover property (@(posedge core_clk) disable iff (reset) isReset);
  cov_service_req: cover property (@(posedge core_clk) disable iff (reset) $rose(serviceRequest));
  cov_query_remote: cover property (@(posedge core_clk) disable iff (reset)
    take && (cmdWord.op == rsc_pkg::CMD_CONTROL_QUERY) && !remoteActive);
  cov_unit_far: cover property (@(posedge core_clk) disable iff (reset) unitSelect == 5'h1E);
  cov_clear_cmd: cover property (@(posedge core_clk) disable iff (reset) isClear);

endmodule
`default_nettype wire

// *** tb/rsc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host controller: offers commands, takes answers after random stalls
module rsc_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Command stream
  output logic cmdValid,
  output var rsc_pkg::rsc_cmd_s cmdWord,
  input wire logic cmdReady,
  // Answer stream
  input wire logic replyValid,
  output logic replyReady
);
  int seed = 32'h4D4B53D9;

  initial begin
    cmdValid = 1'b0;
    cmdWord = '0;
    replyReady = 1'b0;
  end

  // Mix of prompt and slow takes, so commands really stall behind answers
  always @(posedge core_clk) begin
    replyReady <= !reset && (($random(seed) & 3) == 0);
  end

  // Command held until the edge that sees cmdReady high
  task automatic send(input rsc_pkg::rsc_cmd_e op, input logic [7:0] arg, output logic taken);
    int n;
    n = 0;
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdWord <= '{op: op, arg: arg};
    do begin
      @(posedge core_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 200);
    taken = (cmdReady === 1'b1);
    cmdValid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/test_remote_status_command_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_remote_status_command_unit;
  // ==========================================================
  // Signals
  logic core_clk, reset, cmdValid, cmdReady, replyValid, replyReady;
  rsc_pkg::rsc_cmd_s cmdWord;
  logic [7:0] replyData, deviceEvents, statusByte, arg, expUnit, ev;
  logic localLinkFault, localLinkTimeout, serialPoll, panelLocalKey;
  logic flushBuffers, dropAddressing, remoteActive, lockoutActive, serviceRequest;
  logic [4:0] unitSelect;
  logic [1:0] controlCode, expCode;
  logic [7:0] expQ[$];
  logic [7:0] unitArgs[6] = '{8'h00, 8'h1E, 8'h1F, 8'hFF, 8'h03, 8'h01};
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 32'h4D4B53D9;

  rsc_command_unit dut (.core_clk(core_clk), .reset(reset), .cmdValid(cmdValid),
    .cmdWord(cmdWord), .cmdReady(cmdReady), .replyValid(replyValid),
    .replyData(replyData), .replyReady(replyReady), .deviceEvents(deviceEvents),
    .localLinkFault(localLinkFault), .localLinkTimeout(localLinkTimeout),
    .serialPoll(serialPoll), .panelLocalKey(panelLocalKey),
    .flushBuffers(flushBuffers), .dropAddressing(dropAddressing),
    .unitSelect(unitSelect), .controlCode(controlCode), .remoteActive(remoteActive),
    .lockoutActive(lockoutActive), .statusByte(statusByte),
    .serviceRequest(serviceRequest));

  rsc_host_model host (.core_clk(core_clk), .reset(reset), .cmdValid(cmdValid),
    .cmdWord(cmdWord), .cmdReady(cmdReady), .replyValid(replyValid),
    .replyReady(replyReady));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmd(input rsc_pkg::rsc_cmd_e op, input logic [7:0] a);
    logic ok;
    host.send(op, a, ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t command %h not taken", $time, op);
    end
    #1;
  endtask

  // Expected answer is noted before the command goes out
  task automatic query(input rsc_pkg::rsc_cmd_e op, input logic [7:0] exp);
    int n;
    n = 0;
    expQ.push_back(exp);
    cmd(op, 8'h00);
    while (expQ.size() != 0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (expQ.size() != 0) begin
      error_cnt++;
      $display("[FAIL] %0t no answer to %h", $time, op);
      expQ.delete();
    end
    #1;
  endtask

  task automatic strobe(input logic [7:0] e, input logic [3:0] sig);
    @(posedge core_clk);
    deviceEvents <= e;
    {localLinkFault, localLinkTimeout, serialPoll, panelLocalKey} <= sig;
    @(posedge core_clk);
    deviceEvents <= 8'h00;
    {localLinkFault, localLinkTimeout, serialPoll, panelLocalKey} <= 4'h0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic check_ctrl(input logic [1:0] c);
    check({6'h00, controlCode}, {6'h00, c}, "control code");
    check({7'h00, remoteActive}, {7'h00, c != 2'h0}, "remote flag");
    check({7'h00, lockoutActive}, {7'h00, c == 2'h2}, "lockout flag");
  endtask

  task automatic finish_test;
    $display("Summary: errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Answer monitor
  always @(posedge core_clk) begin
    if (reset === 1'b0) begin
      check({7'h00, statusByte[4]}, {7'h00, replyValid}, "message bit");
      check({7'h00, cmdReady}, {7'h00, !replyValid}, "ready while answer waits");
      if (replyValid === 1'b1 && replyReady === 1'b1) begin
        if (expQ.size() == 0) begin
          error_cnt++;
          $display("[FAIL] %0t unexpected answer %h", $time, replyData);
        end else begin
          check(replyData, expQ.pop_front(), "answer");
        end
      end
    end
  end

  // Whole sequence needs a few hundred cycles
  initial begin
    #200000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  // ==========================================================
  // Scenarios
  initial begin
    reset = 1'b1;
    deviceEvents = 8'h00;
    {localLinkFault, localLinkTimeout, serialPoll, panelLocalKey} = 4'h0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    check({3'h0, unitSelect}, 8'h01, "unit after reset");
    check(statusByte, 8'h00, "status after reset");
    check_ctrl(2'h0);
    query(rsc_pkg::CMD_SERVICE_MASK_QUERY, 8'h00);
    query(rsc_pkg::CMD_EVENT_QUERY, rsc_pkg::EVENT_RESET);
    // Completion flag and its query
    cmd(rsc_pkg::CMD_OP_DONE, 8'h00);
    query(rsc_pkg::CMD_EVENT_QUERY, 8'h01);
    query(rsc_pkg::CMD_OP_DONE_QUERY, rsc_pkg::REPLY_DONE);
    // Request through event summary; unused enable bits kept zero
    cmd(rsc_pkg::CMD_EVENT_MASK, 8'h01);
    cmd(rsc_pkg::CMD_SERVICE_MASK, 8'h20);
    check(statusByte, 8'h00, "masked status");
    cmd(rsc_pkg::CMD_OP_DONE, 8'h00);
    @(posedge core_clk);
    #1;
    check(statusByte, 8'h60, "event summary");
    check({7'h00, serviceRequest}, 8'h01, "request set");
    query(rsc_pkg::CMD_SUMMARY_QUERY, 8'h60);
    strobe(8'h00, 4'h2);
    check({7'h00, serviceRequest}, 8'h00, "request after poll");
    check(statusByte, 8'h60, "summary after poll");
    // Local bus fault and timeout bits
    cmd(rsc_pkg::CMD_SERVICE_MASK, 8'h03);
    strobe(8'h00, 4'hC);
    check(statusByte, 8'h63, "link bits");
    check({7'h00, serviceRequest}, 8'h01, "request on link");
    // Communication reset, then queries back to back
    cmd(rsc_pkg::CMD_COMM_RESET, 8'h00);
    check({7'h00, flushBuffers}, 8'h01, "flush pulse");
    check({7'h00, dropAddressing}, 8'h01, "drop pulse");
    check(statusByte, 8'h00, "status cleared");
    @(posedge core_clk);
    #1;
    check({6'h00, flushBuffers, dropAddressing}, 8'h00, "pulses end");
    query(rsc_pkg::CMD_EVENT_QUERY, 8'h00);
    query(rsc_pkg::CMD_SERVICE_MASK_QUERY, 8'h00);
    query(rsc_pkg::CMD_EVENT_MASK_QUERY, 8'h00);
    // Unit numbers, edges and out of range
    expUnit = 8'h01;
    for (int i = 0; i < 7; i++) begin
      arg = (i < 6) ? unitArgs[i] : 8'($unsigned($random(seed)) % 30 + 1);
      cmd(rsc_pkg::CMD_UNIT_SELECT, arg);
      if (arg >= 8'h01 && arg <= 8'h1E) begin
        expUnit = arg;
      end
      check({3'h0, unitSelect}, expUnit, "unit select");
    end
    query(rsc_pkg::CMD_EVENT_QUERY, 8'h00);
    cmd(rsc_pkg::CMD_UNIT_SELECT, 8'h01);
    check({3'h0, unitSelect}, 8'h01, "unit back to master");
    // Control source codes, panel key, query from local
    expCode = 2'h0;
    for (int c = 0; c < 4; c++) begin
      cmd(rsc_pkg::CMD_CONTROL_SRC, 8'(c));
      if (c < 3) begin
        expCode = 2'(c);
      end
      check_ctrl(expCode);
    end
    strobe(8'h00, 4'h1);
    check_ctrl(2'h2);
    cmd(rsc_pkg::CMD_CONTROL_SRC, 8'h01);
    strobe(8'h00, 4'h1);
    check_ctrl(2'h0);
    query(rsc_pkg::CMD_CONTROL_QUERY, 8'h01);
    check_ctrl(2'h1);
    // Wait and empty commands answer nothing
    cmd(rsc_pkg::CMD_WAIT, 8'h00);
    cmd(rsc_pkg::CMD_NONE, 8'h00);
    query(rsc_pkg::CMD_SUMMARY_QUERY, 8'h00);
    // Status clear drops the sticky link bits and flushes, no addressing drop
    strobe(8'h00, 4'h8);
    check(statusByte, 8'h02, "fault bit");
    cmd(rsc_pkg::CMD_CLEAR_STATUS, 8'h00);
    check({6'h00, flushBuffers, dropAddressing}, 8'h02, "clear pulses");
    check(statusByte, 8'h00, "status after clear");
    // Random device events with the event mask closed
    for (int i = 0; i < 4; i++) begin
      ev = 8'($random(seed));
      strobe(ev, 4'h0);
      check(statusByte, 8'h00, "event summary masked");
      query(rsc_pkg::CMD_EVENT_QUERY, ev);
    end
    finish_test();
  end
endmodule
`default_nettype wire
